/* pwc_common_ctrl.sv */
`timescale 1ns/1ps
module pwc_common_ctrl
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // timer units
  input wire logic [5:0] upd_src_evt,
  output pwc_pkg::pwc_tmr_ctl_t tmr_ctl,
  // event sources
  input wire pwc_pkg::pwc_evt_t evt_in,
  input wire logic [4:0] fault_active,
  // outputs and interrupt
  output logic [9:0] out_enable,
  output logic [9:0] out_fault_state,
  output logic irq
);

  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  logic [5:0] upd_block_q;
  logic [13:0] tmr_act_q;
  logic [5:0] pend_q;
  logic [5:0] apply_q;
  logic [17:0] flag_q;
  logic [17:0] flag_d;
  logic [17:0] flag_set;
  logic [17:0] flag_clr;
  logic [17:0] irq_en_q;
  logic irq_q;
  logic [24:0] gate_q;
  logic [4:0] kill;
  logic [4:0] kill_q;
  logic [9:0] oen_q;
  logic [9:0] oen_set;
  logic [9:0] odis_set;
  logic [9:0] ods_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [5:0] force_v;
  logic [5:0] apply_d;

  // update gating register; bit 0 master, 1..5 slaves A..E
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      upd_block_q <= pwc_pkg::RST_UPD_GATE;
    else if (reg_wr && hit(reg_addr, pwc_pkg::OFF_UPD_GATE))
      upd_block_q <= reg_wdata[5:0];
  end

  // action bits live for exactly one cycle after the write
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      tmr_act_q <= 14'h0000;
    else if (reg_wr && hit(reg_addr, pwc_pkg::OFF_TMR_ACT))
      tmr_act_q <= {reg_wdata[13:8], 2'b00, reg_wdata[5:0]};
    else
      tmr_act_q <= 14'h0000;
  end

  assign force_v = tmr_act_q[pwc_pkg::POS_FORCE_XFER +: 6];

  // a source event seen while blocked is held and applied on unblock, unless a forced transfer drops it first
  always_comb
  begin
    for (int i = 0; i < pwc_pkg::NUM_TMR; i++)
    begin
      apply_d[i] = force_v[i] ||
                   (!upd_block_q[i] && (upd_src_evt[i] || pend_q[i]));
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pend_q <= 6'h00;
    else
      pend_q <= ~force_v & upd_block_q & (pend_q | upd_src_evt);
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      apply_q <= 6'h00;
    else
      apply_q <= apply_d;
  end

  assign tmr_ctl.upd_apply = apply_q;
  assign tmr_ctl.force_xfer = force_v;
  assign tmr_ctl.cnt_clear = tmr_act_q[pwc_pkg::POS_CNT_CLEAR +: 6];

  // event flags
  always_comb
  begin
    flag_set = 18'h00000;
    flag_set[pwc_pkg::POS_FAULT_FLAG +: 5] = evt_in.fault;
    flag_set[pwc_pkg::POS_SYS_FAULT] = evt_in.sys_fault;
    flag_set[pwc_pkg::POS_DLL_READY] = evt_in.dll_ready;
    flag_set[pwc_pkg::POS_BURST_PER] = evt_in.burst_period;
    flag_clr = 18'h00000;
    if (reg_wr && hit(reg_addr, pwc_pkg::OFF_FLAG_CLR))
      flag_clr = reg_wdata[17:0] & pwc_pkg::FLAG_MASK;
    flag_d = (flag_q & ~flag_clr) | flag_set;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      flag_q <= pwc_pkg::RST_FLAGS;
    else
      flag_q <= flag_d;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      irq_en_q <= pwc_pkg::RST_IRQ_EN;
    else if (reg_wr && hit(reg_addr, pwc_pkg::OFF_IRQ_EN))
      irq_en_q <= reg_wdata[17:0] & pwc_pkg::FLAG_MASK;
  end

  // registered, so the request trails the flag by one cycle
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      irq_q <= 1'b0;
    else
      irq_q <= |(flag_q & irq_en_q);
  end

  assign irq = irq_q;

  // fault gate, five bits per timer A..E
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      gate_q <= pwc_pkg::RST_FLT_GATE;
    else if (reg_wr && hit(reg_addr, pwc_pkg::OFF_FLT_GATE))
      gate_q <= reg_wdata[24:0];
  end

  // fault_active must be glitch-free: it clears enables with no clock
  genvar t;
  generate
    for (t = 0; t < 5; t++)
    begin : g_kill
      assign kill[t] = |(fault_active & gate_q[t*5 +: 5]);
    end
  endgenerate

  always_comb
  begin
    oen_set = 10'h000;
    odis_set = 10'h000;
    if (reg_wr && hit(reg_addr, pwc_pkg::OFF_OUT_EN_SET))
      oen_set = reg_wdata[9:0];
    if (reg_wr && hit(reg_addr, pwc_pkg::OFF_OUT_DIS))
      odis_set = reg_wdata[9:0];
  end

  genvar o;
  generate
    for (o = 0; o < pwc_pkg::NUM_OUT; o++)
    begin : g_oen
      logic en_q;
      logic en_rst_n;
      assign en_rst_n = resetn & ~kill[o/2];
      always_ff @(posedge core_clk or negedge en_rst_n)
      begin
        if (!en_rst_n)
          en_q <= 1'b0;
        else if (odis_set[o])
          en_q <= 1'b0;
        else if (oen_set[o])
          en_q <= 1'b1;
      end
      assign oen_q[o] = en_q;
    end
  endgenerate

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      kill_q <= 5'h00;
    else
      kill_q <= kill;
  end

  // a new fault moves outputs to fault state; a disable write goes idle
  // a fault rising with the write wins, so that write cannot hide the fault
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      ods_q <= 10'h000;
    else
    begin
      for (int i = 0; i < pwc_pkg::NUM_OUT; i++)
      begin
        if (kill[i/2] && !kill_q[i/2])
          ods_q[i] <= 1'b1;
        else if (odis_set[i])
          ods_q[i] <= 1'b0;
      end
    end
  end

  assign out_enable = oen_q;
  assign out_fault_state = ods_q;

  // read mux; unmapped and write-only addresses read zero
  always_comb
  begin
    rdata_d = pwc_pkg::RST_RDATA;
    if (hit(reg_addr, pwc_pkg::OFF_UPD_GATE))
      rdata_d[5:0] = upd_block_q;
    else if (hit(reg_addr, pwc_pkg::OFF_TMR_ACT))
      rdata_d[13:0] = tmr_act_q;
    else if (hit(reg_addr, pwc_pkg::OFF_FLAG_STAT))
      rdata_d[17:0] = flag_q;
    else if (hit(reg_addr, pwc_pkg::OFF_IRQ_EN))
      rdata_d[17:0] = irq_en_q;
    else if (hit(reg_addr, pwc_pkg::OFF_OUT_EN_SET))
      rdata_d[9:0] = oen_q;
    else if (hit(reg_addr, pwc_pkg::OFF_OUT_DIS_ST))
      rdata_d[9:0] = ods_q;
    else if (hit(reg_addr, pwc_pkg::OFF_FLT_GATE))
      rdata_d[24:0] = gate_q;
  end

  // data valid only in the cycle after the read strobe
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= pwc_pkg::RST_RDATA;
    else if (reg_rd)
      rdata_q <= rdata_d;
    else
      rdata_q <= pwc_pkg::RST_RDATA;
  end

  assign reg_rdata = rdata_q;

endmodule // pwc_common_ctrl

/* pwc_pkg.sv */
package pwc_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_UPD_GATE = 12'h380;
  localparam logic [11:0] OFF_TMR_ACT = 12'h384;
  localparam logic [11:0] OFF_FLAG_STAT = 12'h388;
  localparam logic [11:0] OFF_FLAG_CLR = 12'h38c;
  localparam logic [11:0] OFF_IRQ_EN = 12'h390;
  localparam logic [11:0] OFF_OUT_EN_SET = 12'h394;
  localparam logic [11:0] OFF_OUT_DIS = 12'h398;
  localparam logic [11:0] OFF_OUT_DIS_ST = 12'h39c;
  localparam logic [11:0] OFF_FLT_GATE = 12'h3b0;
  // field positions and widths
  localparam int NUM_TMR = 6;
  localparam int NUM_FLT = 5;
  localparam int NUM_OUT = 10;
  localparam int POS_FORCE_XFER = 0;
  localparam int POS_CNT_CLEAR = 8;
  localparam int POS_FAULT_FLAG = 0;
  localparam int POS_SYS_FAULT = 5;
  localparam int POS_DLL_READY = 16;
  localparam int POS_BURST_PER = 17;
  localparam int FLAG_W = 18;
  localparam int GATE_W = 25;
  // implemented flag positions
  localparam logic [17:0] FLAG_MASK = 18'h3003f;
  // reset values
  localparam logic [5:0] RST_UPD_GATE = 6'h00;
  localparam logic [17:0] RST_FLAGS = 18'h00000;
  localparam logic [17:0] RST_IRQ_EN = 18'h00000;
  localparam logic [24:0] RST_FLT_GATE = 25'h0000000;
  localparam logic [31:0] RST_RDATA = 32'h00000000;

  typedef struct packed {
    logic burst_period;
    logic dll_ready;
    logic sys_fault;
    logic [4:0] fault;
  } pwc_evt_t;

  typedef struct packed {
    logic [5:0] upd_apply;
    logic [5:0] force_xfer;
    logic [5:0] cnt_clear;
  } pwc_tmr_ctl_t;
endpackage

/* pwc_checker.sv */
`timescale 1ns/1ps
module pwc_checker
(
  // clock and reset
  input logic core_clk,
  input logic resetn,
  // register port
  input logic [11:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [31:0] reg_rdata,
  // timers, events, outputs
  input logic [5:0] upd_src_evt,
  input pwc_pkg::pwc_tmr_ctl_t tmr_ctl,
  input pwc_pkg::pwc_evt_t evt_in,
  input logic [4:0] fault_active,
  input logic [9:0] out_enable,
  input logic [9:0] out_fault_state,
  input logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [5:0] gate_q;
  logic [4:0] flt_q;
  logic [5:0] open_evt;
  logic wr_act;
  logic wr_oen;
  // word addresses: 0xe0 update block, 0xe1 action, 0xe5 enable
  assign wr_act = reg_wr && reg_addr[11:2] == 10'he1;
  assign wr_oen = reg_wr && reg_addr[11:2] == 10'he5;
  assign open_evt = upd_src_evt & ~gate_q;
  // shadow copies, only what the properties need
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn) gate_q <= 6'h00;
    else if (reg_wr && reg_addr[11:2] == 10'he0) gate_q <= reg_wdata[5:0];
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn) flt_q <= 5'h00;
    else if (reg_wr && reg_addr[11:2] == 10'hec) flt_q <= reg_wdata[4:0];
  sequence s_forced;
    tmr_ctl.force_xfer != 6'h00;
  endsequence
  a_action_bits:
    assert property (wr_act |=> tmr_ctl.force_xfer == $past(reg_wdata[5:0])
      && tmr_ctl.cnt_clear == $past(reg_wdata[13:8]))
      else $error("action pulses wrong");
  a_self_clear:
    assert property (!wr_act |=> tmr_ctl.cnt_clear == 6'h00
      && tmr_ctl.force_xfer == 6'h00) else $error("action not cleared");
  a_force_apply:
    assert property (s_forced |=> (tmr_ctl.upd_apply
      & $past(tmr_ctl.force_xfer)) == $past(tmr_ctl.force_xfer))
      else $error("forced transfer missing");
  a_update_open:
    assert property (open_evt != 6'h00 |=>
      (tmr_ctl.upd_apply & $past(open_evt)) == $past(open_evt))
      else $error("open update lost");
  a_enable_cause:
    assert property ((out_enable & ~$past(out_enable)) != 10'h000
      |-> $past(wr_oen)) else $error("enable rose unasked");
  a_fault_clear:
    assert property ((fault_active & flt_q) != 5'h00
      |-> out_enable[1:0] == 2'b00) else $error("fault left output on");
  a_fstate_cause:
    assert property ((out_fault_state & ~$past(out_fault_state)) != 10'h000
      |-> $past(fault_active) != 5'h00) else $error("fault state unasked");
  a_read_zero:
    assert property ((!reg_rd || reg_addr[11:2] == 10'he3)
      |=> reg_rdata == 32'h0) else $error("read data not zero");
  a_enable_read:
    assert property ((reg_rd && reg_addr[11:2] == 10'he5)
      |=> reg_rdata == {22'h0, $past(out_enable)})
      else $error("enable status read wrong");
endmodule // pwc_checker
bind pwc_common_ctrl pwc_checker pwc_checker_inst (.core_clk(core_clk),
  .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .upd_src_evt(upd_src_evt), .tmr_ctl(tmr_ctl), .evt_in(evt_in),
  .fault_active(fault_active), .out_enable(out_enable),
  .out_fault_state(out_fault_state), .irq(irq));

/* tb_pwc_common_ctrl.sv */
`timescale 1ns/1ps
module tb_pwc_common_ctrl;
  logic core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, irq;
  logic [11:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, ef, ie, v;
  logic [5:0] upd_src_evt = '0;
  logic [4:0] fault_active = '0;
  logic [9:0] out_enable, out_fault_state;
  pwc_pkg::pwc_tmr_ctl_t tmr_ctl;
  pwc_pkg::pwc_evt_t evt_in = '0;
  int bad_count = 0, compares = 0, seed = 4, m_flag = 0;
  always #2 core_clk = ~core_clk;
  pwc_common_ctrl pwc_common_ctrl_inst (.core_clk(core_clk),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .upd_src_evt(upd_src_evt), .tmr_ctl(tmr_ctl), .evt_in(evt_in),
    .fault_active(fault_active), .out_enable(out_enable),
    .out_fault_state(out_fault_state), .irq(irq));
  task automatic cmp(input logic [31:0] g, e, input string what);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: %s %h not %h", $time, what, g, e);
    end
  endtask
  task automatic chk_reg(input logic [31:0] g, e); cmp(g, e, "read"); endtask
  task automatic chk_port(input logic [31:0] g, e); cmp(g, e, "port"); endtask
  // write strobe; events ride along so set and clear can share a cycle
  task automatic wrx(input logic [11:0] a, input logic [31:0] d,
                     input pwc_pkg::pwc_evt_t ev);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    evt_in <= ev;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    evt_in <= '0;
    // model of the flag register: clear first, then set, so set wins
    if (a == 12'h38c)
      m_flag = m_flag & ~(d & 32'h3003f);
    m_flag = m_flag | 32'(ev.fault) | (32'(ev.sys_fault) << 5)
             | (32'(ev.dll_ready) << 16) | (32'(ev.burst_period) << 17);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wrx(a, d, '0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk_reg(reg_rdata, e);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #20000 bad_count++;
    tally_and_finish();
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    // reset values, reserved holes included
    for (int a = 12'h380; a <= 12'h3b0; a += 4) rd(12'(a), 32'h0);
    // fault one always enabled, burst period always masked off
    ie = ($random(seed) & 32'h1003f) | 32'h1;
    wr(12'h390, ie);
    rd(12'h390, ie);
    for (int i = 0; i < 8; i++)
    begin
      ef = 32'h1 << (i < 6 ? i : i + 10);
      wrx(12'h3f0, 32'h0, 8'(1 << i));
      rd(12'h388, ef);
      chk_port(irq, |(ef & ie));
      wrx(12'h38c, ~ef, '0);
      wrx(12'h38c, ef, 8'(1 << i));
      rd(12'h388, m_flag);
      wr(12'h38c, ef);
      rd(12'h388, 32'h0);
      chk_port(irq, 32'h0);
    end
    repeat (4)
    begin
      v = $random(seed) & 32'h3f3f;
      wr(12'h384, v);
      #1 chk_port(tmr_ctl.cnt_clear, v[13:8]);
      chk_port(tmr_ctl.force_xfer, v[5:0]);
      @(posedge core_clk);
      #1 chk_port(tmr_ctl.upd_apply, v[5:0]);
      rd(12'h384, 32'h0);
    end
    v = ($random(seed) & 32'h3f) | 32'h3;
    wr(12'h380, v);
    rd(12'h380, v);
    @(posedge core_clk);
    upd_src_evt <= 6'h3f;
    @(posedge core_clk);
    upd_src_evt <= 6'h00;
    #1 chk_port(tmr_ctl.upd_apply, ~v[5:0] & 6'h3f);
    // master forced while blocked: its pending update must be dropped
    wr(12'h384, 32'h1);
    @(posedge core_clk);
    #1 chk_port(tmr_ctl.upd_apply, 32'h1);
    wr(12'h380, 32'h0);
    @(posedge core_clk);
    #1 chk_port(tmr_ctl.upd_apply, v[5:0] & 6'h3e);
    wr(12'h394, 32'h3ff);
    wr(12'h394, 32'h0);
    rd(12'h394, 32'h3ff);
    wr(12'h398, 32'h1);
    rd(12'h394, 32'h3fe);
    rd(12'h39c, 32'h0);
    // only fault one is gated for timer A; fault two must be ignored
    wr(12'h3b0, 32'h1);
    fault_active <= 5'h03;
    #1 chk_port(out_enable, 32'h3fc);
    @(posedge core_clk);
    #1 chk_port(out_fault_state, 32'h003);
    wr(12'h394, 32'h3);
    rd(12'h394, 32'h3fc);
    @(posedge core_clk);
    fault_active <= 5'h00;
    wr(12'h394, 32'h3);
    rd(12'h394, 32'h3ff);
    wr(12'h398, 32'h2);
    rd(12'h39c, 32'h001);
    rd(12'h394, 32'h3fd);
    tally_and_finish();
  end
endmodule // tb_pwc_common_ctrl
